/* rtl/eesl_pkg.sv */
// Purpose: Shared constants and types of the serial EEPROM write-path slave.
// Assumes: System clock of 250 MHz; all times below are turned into cycles here.
// Notes:   Counts are derived from the printed times, never typed as raw figures.
package eesl_pkg;

  // ----------------------------------------------------------------
  // Clock and program-cycle timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int PROG_TIME_STD_MS = 10;
  localparam int PROG_TIME_LV_MS = 15;
  // ms times kHz gives whole cycles; no time is rounded
  localparam int PROG_CYC_STD = PROG_TIME_STD_MS * CLK_FREQ_KHZ;
  localparam int PROG_CYC_LV = PROG_TIME_LV_MS * CLK_FREQ_KHZ;

  // ----------------------------------------------------------------
  // Address and byte layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int ADDR_HI_W = 5;
  localparam int PAGE_W = 5;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int PROT_BIT = 12;
  // Device-type field; value is arbitrary
  localparam logic [3:0] DEV_TYPE_DFLT = 4'h5;

  // ----------------------------------------------------------------
  // Pin bundle order and reset image
  // ----------------------------------------------------------------
  // {supply_low, wp, sel2, sel1, sel0, sda, scl}; idle bus reads high
  localparam int PIN_W = 7;
  localparam logic [6:0] PIN_RST = 7'h03;
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Protocol states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADR,
    ST_ADRHI,
    ST_ADRLO,
    ST_WDATA,
    ST_RDATA,
    ST_WAITSTOP
  } eesl_state_t;

endpackage

/* rtl/eesl_pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to clk_sys_i.
// Notes:   A change is taken only when stages two and three agree.
`timescale 1ns/1ns
module eesl_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Pins in, filtered levels out
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] pin_o
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] agree;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Per-bit agreement; a lone glitch cycle never reaches the output
  assign agree = ~(s2_ff ^ s3_ff);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pin_o <= INIT;
    end else begin
      pin_o <= (pin_o & ~agree) | (s2_ff & agree);
    end
  end

endmodule

/* rtl/eesl_prog_timer.sv */
// Purpose: Self-timed nonvolatile program cycle; busy for a fixed cycle count.
// Assumes: start_i is a one-cycle pulse on clk_sys_i.
// Notes:   Starts during a running cycle are ignored; only reset aborts it.
`timescale 1ns/1ns
module eesl_prog_timer #(
  parameter int CYCLES = eesl_pkg::PROG_CYC_STD
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Control
  input wire logic start_i,
  output logic busy_o
);

  localparam int CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] cnt_ff;

  // Short counts would break the busy-hold checks downstream
  if (CYCLES < 8) begin : g_bad_cycles
    $error("eesl_prog_timer: CYCLES must be at least 8");
  end

  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  // Only reset (power loss) ends a cycle early
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt_ff <= '0;
      busy_o <= 1'b0;
    end else if (busy_o) begin
      cnt_ff <= cnt_ff - CNT_W'(1);
      busy_o <= (cnt_ff != CNT_W'(1));
    end else if (start_i) begin
      cnt_ff <= CNT_W'(CYCLES);
      busy_o <= 1'b1;
    end
  end

endmodule

/* rtl/eesl_wpath.sv */
// Purpose: Two-wire slave front end of an 8K x 8 EEPROM: write path and read acks.
// Assumes: Pins are asynchronous; the array sits outside and reads combinationally.
// Notes:   Bytes go to an external page latch; prog_start_o commits the page.
// How it works
// - Write-protect high refuses programming of the upper half; reads stay open.
// - Write-protect low allows reading and programming everywhere.
// - Protected write: ack address bytes, nack first data byte, no program.
// - Data line changes only while clock is low, except start and stop.
// - Falling data with clock high is a start; nothing counts before one.
// - Rising data with clock high is a stop; it ends the transfer, standby.
// - Transmitter releases after eight bits; receiver pulls low on the ninth.
// - Ack a matching slave address, then every byte of a write.
// - Read: send eight bits, sample ack; continue on ack, else await stop.
// - Type field on top, three select bits must equal the strap pins.
// - Address byte bit zero: one reads, zero writes.
// - Two word-address bytes, high first; only five high-byte bits count.
// - Byte write: ack low address, ack data, program on stop.
// - During a program cycle the bus is ignored entirely.
// - Page write: up to thirty-one more bytes, each acked, one cycle.
// - Address counter advances per data byte and wraps past thirty-two.
// - Polling: no ack while programming, ack once done.
// - Lockout armed from write bit to stop; low supply blocks ack, program.
// - A started program cycle cannot be aborted by the bus.
// - Program cycle ends within 10 ms standard or 15 ms low voltage.
`timescale 1ns/1ns
module eesl_wpath #(
  parameter int PROG_CYCLES = eesl_pkg::PROG_CYC_STD,
  parameter bit LOCKOUT_EN = 1'b1,
  parameter logic [3:0] DEV_TYPE = eesl_pkg::DEV_TYPE_DFLT
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Two-wire bus; data is open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Straps and supply monitor
  input wire logic dev_select_bit0_i,
  input wire logic dev_select_bit1_i,
  input wire logic dev_select_bit2_i,
  input wire logic wp_i,
  input wire logic supply_low_i,
  // Array page latch, commit and read port
  output logic wr_en_o,
  output logic [eesl_pkg::ADDR_W-1:0] wr_addr_o,
  output logic [eesl_pkg::BYTE_W-1:0] wr_data_o,
  output logic prog_start_o,
  output logic [eesl_pkg::ADDR_W-1:0] mem_addr_o,
  input wire logic [eesl_pkg::BYTE_W-1:0] rd_data_i,
  // Status
  output logic busy_o,
  output logic standby_o,
  output logic low_supply_program_inhibit_o
);

  // ----------------------------------------------------------------
  // Pin synchronisation and bus events
  // ----------------------------------------------------------------
  logic [eesl_pkg::PIN_W-1:0] pin_q;
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_s;
  logic sda_s;
  logic [2:0] sel_s;
  logic wp_s;
  logic supply_low_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  eesl_pin_sync #(
    .WIDTH(eesl_pkg::PIN_W),
    .INIT(eesl_pkg::PIN_RST)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .pin_i({supply_low_i, wp_i, dev_select_bit2_i, dev_select_bit1_i,
            dev_select_bit0_i, sda_i, scl_i}),
    .pin_o(pin_q)
  );

  assign scl_s = pin_q[0];
  assign sda_s = pin_q[1];
  assign sel_s = pin_q[4:2];
  assign wp_s = pin_q[5];
  assign supply_low_s = pin_q[6];

  // Previous filtered levels for edge finding
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  // Master owns the clock; we only react to its edges
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  typedef eesl_pkg::eesl_state_t eesl_state_t;
  eesl_state_t st_ff;
  eesl_state_t nxt_st;
  logic [3:0] cnt_ff;
  logic ackph_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic [eesl_pkg::ADDR_W-1:0] addr_ff;
  logic first_ff;
  logic mack_ff;
  logic arm_ff;
  logic pend_ff;
  logic active;
  logic byte_done;
  logic ack_end;
  logic nxt_ack;
  logic lock_trip;
  logic prot;
  logic rd_load;
  logic byte_ok;

  // Busy makes every bus input invisible
  assign active = ~busy_o & ~start_det & ~stop_det & (st_ff != eesl_pkg::ST_IDLE);
  assign byte_done = active & scl_fall & ~ackph_ff & (cnt_ff == eesl_pkg::BITS_PER_BYTE);
  assign ack_end = active & scl_fall & ackph_ff;
  assign lock_trip = LOCKOUT_EN & arm_ff & supply_low_s;
  assign prot = wp_s & addr_ff[eesl_pkg::PROT_BIT];
  assign rd_load = ack_end & (st_ff == eesl_pkg::ST_RDATA) & (first_ff | mack_ff);
  assign byte_ok = byte_done & (st_ff == eesl_pkg::ST_WDATA) & nxt_ack;

  // Next state and ack decision at the end of each received byte
  always_comb begin
    nxt_st = eesl_pkg::ST_WAITSTOP;
    nxt_ack = 1'b0;
    case (st_ff)
      eesl_pkg::ST_DEVADR: begin
        if (rx_ff[7:4] == DEV_TYPE && rx_ff[3:1] == sel_s) begin
          // An armed lockout under low supply refuses a repeated-start read too
          if (rx_ff[0] && !lock_trip) begin
            nxt_st = eesl_pkg::ST_RDATA;
            nxt_ack = 1'b1;
          end else if (!rx_ff[0] && !(LOCKOUT_EN && supply_low_s)) begin
            nxt_st = eesl_pkg::ST_ADRHI;
            nxt_ack = 1'b1;
          end
        end
      end
      eesl_pkg::ST_ADRHI: begin
        nxt_st = lock_trip ? eesl_pkg::ST_WAITSTOP : eesl_pkg::ST_ADRLO;
        nxt_ack = ~lock_trip;
      end
      eesl_pkg::ST_ADRLO: begin
        nxt_st = lock_trip ? eesl_pkg::ST_WAITSTOP : eesl_pkg::ST_WDATA;
        nxt_ack = ~lock_trip;
      end
      eesl_pkg::ST_WDATA: begin
        nxt_st = (prot | lock_trip) ? eesl_pkg::ST_WAITSTOP : eesl_pkg::ST_WDATA;
        nxt_ack = ~(prot | lock_trip);
      end
      eesl_pkg::ST_RDATA: begin
        nxt_st = eesl_pkg::ST_RDATA;
      end
      default: begin
        nxt_st = eesl_pkg::ST_WAITSTOP;
      end
    endcase
  end

  // State register; start re-enters from anywhere, stop returns to idle
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || busy_o) begin
      st_ff <= eesl_pkg::ST_IDLE;
    end else if (start_det) begin
      st_ff <= eesl_pkg::ST_DEVADR;
    end else if (stop_det) begin
      st_ff <= eesl_pkg::ST_IDLE;
    end else if (byte_done) begin
      st_ff <= nxt_st;
    end else if (ack_end && st_ff == eesl_pkg::ST_RDATA && !first_ff && !mack_ff) begin
      st_ff <= eesl_pkg::ST_WAITSTOP;
    end
  end

  // Bit engine: sample on rising clock, ninth clock is the ack slot
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !active) begin
      cnt_ff <= 4'h0;
      ackph_ff <= 1'b0;
    end else if (scl_rise && !ackph_ff && cnt_ff != eesl_pkg::BITS_PER_BYTE) begin
      rx_ff <= {rx_ff[6:0], sda_s};
      cnt_ff <= cnt_ff + 4'h1;
    end else if (byte_done) begin
      ackph_ff <= 1'b1;
    end else if (ack_end) begin
      ackph_ff <= 1'b0;
      cnt_ff <= 4'h0;
    end
  end

  // Read-side flags: first byte after address, and master ack sample
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !active) begin
      first_ff <= 1'b0;
      mack_ff <= 1'b0;
    end else if (byte_done) begin
      first_ff <= (st_ff == eesl_pkg::ST_DEVADR) & rx_ff[0] & nxt_ack;
    end else if (scl_rise && ackph_ff && st_ff == eesl_pkg::ST_RDATA) begin
      mack_ff <= ~sda_s;
    end else if (ack_end) begin
      first_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Address counter and write port
  // ----------------------------------------------------------------
  // Writes wrap inside the page; reads run over the whole array
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      addr_ff <= eesl_pkg::ADDR_RST;
    end else if (byte_done && st_ff == eesl_pkg::ST_ADRHI) begin
      addr_ff[12:8] <= rx_ff[eesl_pkg::ADDR_HI_W-1:0];
    end else if (byte_done && st_ff == eesl_pkg::ST_ADRLO) begin
      addr_ff[7:0] <= rx_ff;
    end else if (byte_ok) begin
      addr_ff[4:0] <= addr_ff[4:0] + 5'h01;
    end else if (rd_load) begin
      addr_ff <= addr_ff + 13'h0001;
    end
  end

  assign mem_addr_o = addr_ff;

  // One latch write per accepted data byte
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wr_en_o <= 1'b0;
      wr_addr_o <= eesl_pkg::ADDR_RST;
      wr_data_o <= eesl_pkg::BYTE_RST;
    end else begin
      wr_en_o <= byte_ok;
      if (byte_ok) begin
        wr_addr_o <= addr_ff;
        wr_data_o <= rx_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data line drive
  // ----------------------------------------------------------------
  // Open drain: only ever pull low, and only right after a clock fall
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !active) begin
      sda_oe_o <= 1'b0;
      tx_ff <= eesl_pkg::BYTE_RST;
    end else if (rd_load) begin
      tx_ff <= rd_data_i;
      sda_oe_o <= ~rd_data_i[7];
    end else if (byte_done) begin
      sda_oe_o <= nxt_ack & (st_ff != eesl_pkg::ST_RDATA);
    end else if (ack_end) begin
      sda_oe_o <= 1'b0;
    end else if (scl_fall && st_ff == eesl_pkg::ST_RDATA && !ackph_ff) begin
      tx_ff <= {tx_ff[6:0], 1'b0};
      sda_oe_o <= ~tx_ff[6];
    end
  end

  assign sda_o = 1'b0;

  // ----------------------------------------------------------------
  // Lockout, pending page and program launch
  // ----------------------------------------------------------------
  // Lockout armed by a write bit and held until the stop
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || stop_det || busy_o) begin
      arm_ff <= 1'b0;
      low_supply_program_inhibit_o <= 1'b0;
    end else begin
      if (byte_done && st_ff == eesl_pkg::ST_DEVADR && !rx_ff[0]) begin
        arm_ff <= LOCKOUT_EN;
      end
      if (lock_trip || (byte_done && st_ff == eesl_pkg::ST_DEVADR && !rx_ff[0] &&
          LOCKOUT_EN && supply_low_s)) begin
        low_supply_program_inhibit_o <= 1'b1;
      end
    end
  end

  // Data waiting for commit; a refused byte spoils nothing already latched
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || stop_det || busy_o) begin
      pend_ff <= 1'b0;
    end else if (byte_ok) begin
      pend_ff <= 1'b1;
    end
  end

  // Program only on a stop with data and no lockout trip
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      prog_start_o <= 1'b0;
    end else begin
      prog_start_o <= stop_det & ~busy_o & pend_ff & ~lock_trip &
                      ~low_supply_program_inhibit_o;
    end
  end

  eesl_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .start_i(prog_start_o),
    .busy_o(busy_o)
  );

  // Standby follows idle one cycle later
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      standby_o <= 1'b1;
    end else begin
      standby_o <= (st_ff == eesl_pkg::ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  property p_prot_nack;
    byte_done && st_ff == eesl_pkg::ST_WDATA && prot |=> !sda_oe_o && !wr_en_o;
  endproperty
  a_prot_nack: assert property (p_prot_nack) else $error("protected byte acked");

  property p_sel_nack;
    byte_done && st_ff == eesl_pkg::ST_DEVADR && rx_ff[3:1] != sel_s |=> !sda_oe_o;
  endproperty
  a_sel_nack: assert property (p_sel_nack) else $error("foreign address acked");

  property p_adrlo_ack;
    byte_done && st_ff == eesl_pkg::ST_ADRLO && !lock_trip |=> sda_oe_o;
  endproperty
  a_adrlo_ack: assert property (p_adrlo_ack) else $error("low address not acked");

  property p_lock_nack;
    byte_done && lock_trip && st_ff != eesl_pkg::ST_RDATA |=> !sda_oe_o ##1 !prog_start_o;
  endproperty
  a_lock_nack: assert property (p_lock_nack) else $error("ack under lockout");

  property p_start;
    start_det && !busy_o |=> st_ff == eesl_pkg::ST_DEVADR;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_stop;
    stop_det && !busy_o |=> st_ff == eesl_pkg::ST_IDLE ##1 standby_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");

  property p_busy_quiet;
    busy_o |-> !sda_oe_o && !wr_en_o && st_ff == eesl_pkg::ST_IDLE;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("bus active while busy");

  property p_prog_hold;
    prog_start_o |=> busy_o [*8];
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("program cycle cut short");

  property p_page;
    wr_en_o |-> addr_ff[12:5] == wr_addr_o[12:5];
  endproperty
  a_page: assert property (p_page) else $error("write left its page");

  property p_drive_edge;
    $rose(sda_oe_o) |-> $past(scl_fall);
  endproperty
  a_drive_edge: assert property (p_drive_edge) else $error("drive with clock high");

endmodule

/* sim/eesl_bus_master.sv */
// Purpose: Behavioural two-wire bus master driving the write-path slave.
// Assumes: Data line has a pull-up; the bench resolves the wired level.
// Notes:   A bit is 31 system clocks (124 ns, nearest to 125 ns); levels move after an edge.
`timescale 1ns/1ns
module eesl_bus_master (
  // Clock
  input wire logic clk_i,
  // Bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Idle bus: both lines released
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Quarter of a bit time, stepped off the sampling edge
  task automatic q(input int n = 8);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Data moves mid-low only; the master alone makes the clock
  task automatic bit_io(input logic b, output logic s);
    sda_o = b;
    q();
    scl_o = 1'b1;
    q();
    s = sda_i;
    q();
    scl_o = 1'b0;
    // Short last quarter keeps the bit period near 125 ns
    q(7);
  endtask

  // Data falls with clock high; serves as repeated start too
  task automatic start();
    sda_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_o = 1'b0;
    q();
    scl_o = 1'b0;
    q();
  endtask

  // Data rises with clock high
  task automatic stop();
    sda_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_o = 1'b1;
    q();
    q();
  endtask

  // MSB first, then release for the ninth-clock ack
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Receive a byte, then ack or leave the line high
  task automatic rd_byte(input logic ack_in, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~ack_in, s);
  endtask
endmodule

/* sim/testbench.sv */
// Purpose: Self-checking bench for the two-wire EEPROM write path.
// Assumes: Short program cycle; array modelled as a fixed address function.
// Notes:   Table rows cover byte writes; page, polling and reads follow.
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [2:0] sel;
    logic [2:0] asel;
    logic wp;
    logic low;
    logic [12:0] addr;
    logic [7:0] data;
    logic a_ack;
    logic d_ack;
  } eesl_tb_row_t;
  // Short cycle so polling still sees a busy phase or two
  localparam int PCYC = 1024;
  localparam logic [7:0] ADR_W = {eesl_pkg::DEV_TYPE_DFLT, 3'h2, 1'b0};
  localparam eesl_tb_row_t ROWS [6] = '{
    '{3'h0, 3'h0, 1'b0, 1'b0, 13'h0010, 8'h3c, 1'b1, 1'b1},
    '{3'h5, 3'h5, 1'b1, 1'b0, 13'h0123, 8'h96, 1'b1, 1'b1},
    '{3'h7, 3'h7, 1'b1, 1'b0, 13'h1800, 8'h55, 1'b1, 1'b0},
    '{3'h3, 3'h6, 1'b0, 1'b0, 13'h0200, 8'h11, 1'b0, 1'b0},
    '{3'h2, 3'h2, 1'b0, 1'b0, 13'h1fff, 8'hc3, 1'b1, 1'b1},
    '{3'h4, 3'h4, 1'b0, 1'b1, 13'h0300, 8'h77, 1'b0, 1'b0}};
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [2:0] sel = 3'h0;
  logic wp = 1'b0;
  logic low = 1'b0;
  logic scl, m_sda, sda, sda_out, sda_oe, wr_en, prog, busy, standby, inh, a;
  logic [12:0] wr_addr, mem_addr, lst_a;
  logic [7:0] wr_data, rd_data, lst_d, d;
  int err_total = 0;
  int compares = 0;
  int wr_cnt = 0;
  int prg_cnt = 0;

  // Clock and wired-AND data line
  always #2 clk_sys = ~clk_sys;
  assign sda = m_sda & (sda_oe ? sda_out : 1'b1);
  assign rd_data = f(mem_addr);

  eesl_bus_master mst_u (.clk_i(clk_sys), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
  eesl_wpath #(.PROG_CYCLES(PCYC)) dut_u (
    .clk_sys_i(clk_sys), .srst_i(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_out),
    .sda_oe_o(sda_oe), .dev_select_bit0_i(sel[0]), .dev_select_bit1_i(sel[1]),
    .dev_select_bit2_i(sel[2]), .wp_i(wp), .supply_low_i(low), .wr_en_o(wr_en),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .prog_start_o(prog), .mem_addr_o(mem_addr),
    .rd_data_i(rd_data), .busy_o(busy), .standby_o(standby),
    .low_supply_program_inhibit_o(inh));

  // Array contents: upper bits mixed in so a wrong wrap shows
  function automatic logic [7:0] f(input logic [12:0] x);
    return x[7:0] ^ {3'h5, x[12:8]};
  endfunction

  // Latch writes and program starts as they pulse
  always @(posedge clk_sys) begin
    if (wr_en === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      lst_a <= wr_addr;
      lst_d <= wr_data;
    end
    if (prog === 1'b1) begin
      prg_cnt <= prg_cnt + 1;
    end
  end

  task automatic stop_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic cmp_val(input string n, input logic [12:0] e, input logic [12:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask

  // Bounded wait for the program cycle to end
  task automatic wait_idle();
    for (int i = 0; i < PCYC + 400 && busy !== 1'b0; i++) begin
      @(posedge clk_sys);
    end
    if (busy !== 1'b0) begin
      err_total++;
      stop_test();
    end
    mst_u.q();
  endtask

  // One byte write; nacked bytes must stay nacked until the stop
  task automatic do_row(input eesl_tb_row_t r);
    int w0, p0;
    w0 = wr_cnt;
    p0 = prg_cnt;
    sel = r.sel;
    wp = r.wp;
    low = r.low;
    mst_u.q();
    mst_u.start();
    mst_u.wr_byte({eesl_pkg::DEV_TYPE_DFLT, r.asel, 1'b0}, a);
    cmp_bit("slave ack", r.a_ack, a);
    cmp_bit("inhibit", r.low, inh);
    mst_u.wr_byte({3'h0, r.addr[12:8]}, a);
    cmp_bit("addr hi ack", r.a_ack, a);
    mst_u.wr_byte(r.addr[7:0], a);
    cmp_bit("addr lo ack", r.a_ack, a);
    mst_u.wr_byte(r.data, a);
    cmp_bit("data ack", r.d_ack, a);
    mst_u.stop();
    cmp_val("prog count", 13'(r.d_ack), 13'(prg_cnt - p0));
    cmp_val("wr count", 13'(r.d_ack), 13'(wr_cnt - w0));
    if (r.d_ack) begin
      cmp_val("wr addr", r.addr, lst_a);
      cmp_val("wr data", 13'(r.data), 13'(lst_d));
    end
    wait_idle();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int w0, p0;
    repeat (10) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    mst_u.q();
    cmp_bit("standby rst", 1'b1, standby);
    cmp_bit("busy rst", 1'b0, busy);
    cmp_bit("oe rst", 1'b0, sda_oe);
    foreach (ROWS[i]) begin
      do_row(ROWS[i]);
    end
    // Page of 33 bytes from offset 5: one wrap, lands back on the start
    low = 1'b0;
    sel = 3'h2;
    w0 = wr_cnt;
    p0 = prg_cnt;
    mst_u.start();
    mst_u.wr_byte(ADR_W, a);
    mst_u.wr_byte(8'h00, a);
    mst_u.wr_byte(8'h45, a);
    for (int i = 0; i < 33; i++) begin
      mst_u.wr_byte(8'(i), a);
      cmp_bit("page ack", 1'b1, a);
    end
    mst_u.stop();
    cmp_val("page writes", 13'd33, 13'(wr_cnt - w0));
    cmp_val("wrap addr", 13'h0045, lst_a);
    cmp_val("wrap data", 13'h0020, 13'(lst_d));
    cmp_val("page prog", 13'd1, 13'(prg_cnt - p0));
    // Poll at once; busy must ride through the bus traffic
    mst_u.start();
    mst_u.wr_byte(ADR_W, a);
    cmp_bit("poll busy", 1'b0, a);
    cmp_bit("busy held", 1'b1, busy);
    for (int i = 0; i < 8 && a !== 1'b1; i++) begin
      mst_u.stop();
      mst_u.start();
      mst_u.wr_byte(ADR_W, a);
    end
    cmp_bit("poll done", 1'b1, a);
    // Dummy write to the top, repeated start, read across the rollover
    wp = 1'b1;
    p0 = prg_cnt;
    mst_u.wr_byte(8'h1f, a);
    mst_u.wr_byte(8'hff, a);
    mst_u.start();
    mst_u.wr_byte(ADR_W | 8'h01, a);
    cmp_bit("read ack", 1'b1, a);
    mst_u.rd_byte(1'b1, d);
    cmp_val("read top", 13'(f(13'h1fff)), 13'(d));
    mst_u.rd_byte(1'b0, d);
    cmp_val("read wrap", 13'(f(13'h0000)), 13'(d));
    cmp_bit("oe released", 1'b0, sda_oe);
    mst_u.stop();
    cmp_bit("standby", 1'b1, standby);
    cmp_val("read prog", 13'h0000, 13'(prg_cnt - p0));
    stop_test();
  end
endmodule
